// ==== ppdew_pkg.sv ====
// package for the phy power-down and energy wake block
// assumes an apb slave with 32-bit data and byte addresses
package ppdew_pkg;
    localparam logic [7:0] PPDEW_PWR_CTRL_OFS = 8'h00; // per-port power-down controls
    localparam logic [7:0] PPDEW_PWR_STAT_OFS = 8'h04; // per-port power state
    localparam logic [7:0] PPDEW_SRC1_OFS     = 8'h08; // port 1 source flags, write 1 clears
    localparam logic [7:0] PPDEW_SRC2_OFS     = 8'h0c; // port 2 source flags, write 1 clears
    localparam logic [7:0] PPDEW_MASK1_OFS    = 8'h10; // port 1 event mask
    localparam logic [7:0] PPDEW_MASK2_OFS    = 8'h14; // port 2 event mask
    localparam logic [7:0] PPDEW_TOP_STS_OFS  = 8'h18; // top_irq_status, read only
    localparam logic [7:0] PPDEW_TOP_EN_OFS   = 8'h1c; // top enable
    localparam logic [7:0] PPDEW_TOP_CLR_OFS  = 8'h20; // top clear, write only
    localparam logic [7:0] PPDEW_IRQ_CFG_OFS  = 8'h24; // irq pin output enable
    localparam int PPDEW_ENERGY_BIT = 7;               // energy_event_mask_bit position
    localparam int PPDEW_GPD_BIT    = 0;               // general power-down, per byte lane port
    localparam int PPDEW_EDPD_BIT   = 1;               // energy-detect power-down enable
    localparam int PPDEW_P1_BIT     = 0;               // port1_phy_event position
    localparam int PPDEW_P2_BIT     = 1;               // port2_phy_event position
    localparam int PPDEW_WAKE_BIT   = 2;               // energy wake event position
    localparam logic [7:0] PPDEW_MASK_RST = 8'h00;     // all phy events masked at reset

    typedef enum logic [1:0] {
        PPDEW_RUN   = 2'b00,
        PPDEW_EDPD  = 2'b01,
        PPDEW_GPD   = 2'b11
    } ppdew_pstate_t;

    // apb request bundle
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } ppdew_apb_req_t;
endpackage

// ==== ppdew_port.sv ====
// one phy port: power state machine, energy flag and masked event
// assumes energy detector input is already synchronised to clk
`timescale 1ns/100ps
module ppdew_port (
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    input  wire logic                   gpdReq,
    input  wire logic                   edpdEn,
    input  wire logic                   energy,
    input  wire logic                   clrFlag,
    input  wire logic                   maskBit,
    output ppdew_pkg::ppdew_pstate_t    pstate,
    output logic                        flag,
    output logic                        event_out,
    output logic                        wake
);
    import ppdew_pkg::*;
    ppdew_pstate_t next_pstate;
    logic          next_flag;
    logic          energyRise;
    logic          energyQ;

    // power state: gpd only left on command, edpd leaves on energy
    always_comb begin
        next_pstate = pstate;
        case (pstate)
            PPDEW_RUN:  if (gpdReq) next_pstate = PPDEW_GPD;
                        else if (edpdEn && !energy) next_pstate = PPDEW_EDPD;
            PPDEW_EDPD: if (gpdReq) next_pstate = PPDEW_GPD;
                        else if (energy || !edpdEn) next_pstate = PPDEW_RUN;
            PPDEW_GPD:  if (!gpdReq) next_pstate = PPDEW_RUN;
            default:    next_pstate = PPDEW_RUN;
        endcase
    end

    // flag latches on energy rising edge; set beats a clear in the same cycle
    assign energyRise = energy && !energyQ;
    always_comb begin
        next_flag = flag;
        if (clrFlag) next_flag = 1'b0;
        if (energyRise) next_flag = 1'b1;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pstate    <= PPDEW_RUN;
            flag      <= 1'b0;
            energyQ   <= 1'b0;
            event_out <= 1'b0;
            wake      <= 1'b0;
        end else begin
            pstate    <= next_pstate;
            flag      <= next_flag;
            energyQ   <= energy;
            event_out <= next_flag && maskBit;
            wake      <= (pstate == PPDEW_EDPD) && (next_pstate == PPDEW_RUN);
        end
    end

    edpd_wake_a: assert property (@(posedge clk) disable iff (sys_rst)
        pstate == PPDEW_EDPD && energy && !gpdReq |=> pstate == PPDEW_RUN)
        else $error("edpd did not wake on energy");
    gpd_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        pstate == PPDEW_GPD && gpdReq |=> pstate == PPDEW_GPD)
        else $error("gpd left without command");
    flag_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        flag && !clrFlag |=> flag)
        else $error("energy flag lost without clear");
    flag_set_a: assert property (@(posedge clk) disable iff (sys_rst)
        energyRise |=> flag)
        else $error("energy flag not set");
    mask_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
        !maskBit |=> !event_out)
        else $error("masked event raised");
endmodule

// ==== ppdew_top.sv ====
// phy power-down and energy wake block with apb registers and irq pin
// assumes cable energy inputs come from the analog detectors, asynchronous
//
// Summary of operation
// - each of the two phys has its own general and energy-detect power-down controls.
// - general power-down shuts the phy except the management interface, so registers stay live.
// - in energy-detect power-down a phy wakes when its detector sees cable energy.
// - the energy-on event reaches the interrupt only when mask bit 7 is set.
// - port 1 events set port1_phy_event and port 2 events set port2_phy_event in top status.
// - the per-port events are sources of the irq pin.
// - a port event asserts the pin only with mask bit, top enable bit and pin output enable all set; the wake bit needs no mask bit.
// - a top phy event bit stays set until the phy source flag or its mask bit 7 is cleared.
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module ppdew_top (
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    input  wire ppdew_pkg::ppdew_apb_req_t apbReq,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic [1:0]             cableEnergy,
    output logic [1:0]                  phyPowerDown,
    output logic [1:0]                  phyMgmtAlive,
    output logic                        irq
);
    import ppdew_pkg::*;
    logic [1:0]          energyS1;
    logic [1:0]          energyS2;
    logic [1:0]          gpdReq;
    logic [1:0]          edpdEn;
    logic [1:0]          clrFlag;
    logic [7:0]          mask [2];
    logic [1:0]          flag;
    logic [1:0]          portEvt;
    logic [1:0]          wake;
    ppdew_pstate_t       pstate [2];
    logic [2:0]          topSts;
    logic [2:0]          topEn;
    logic                irqOe;
    logic                wr;
    logic                rd;
    logic [1:0]          next_gpdReq;
    logic [1:0]          next_edpdEn;
    logic [7:0]          next_mask [2];
    logic [2:0]          next_topSts;
    logic [2:0]          next_topEn;
    logic                next_irqOe;
    logic [31:0]         next_prdata;
    logic                next_pslverr;
    logic                hit;

    // writes land only at the completing access edge, where the master samples pready
    assign wr = apbReq.psel && apbReq.penable && pready && apbReq.pwrite;
    assign rd = apbReq.psel && !apbReq.penable && !apbReq.pwrite;

    // two-stage synchronisers on the detector lines
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            energyS1 <= 2'h0;
            energyS2 <= 2'h0;
        end else begin
            energyS1 <= cableEnergy;
            energyS2 <= energyS1;
        end
    end

    // source flag clears, write one to bit 7 of the port's source register
    assign clrFlag[0] = wr && apbReq.paddr == PPDEW_SRC1_OFS && apbReq.pwdata[PPDEW_ENERGY_BIT];
    assign clrFlag[1] = wr && apbReq.paddr == PPDEW_SRC2_OFS && apbReq.pwdata[PPDEW_ENERGY_BIT];

    // one port instance per phy, independent controls
    for (genvar p = 0; p < 2; p++) begin : gPort
        ppdew_port uPort (
            .clk       (clk),
            .sys_rst   (sys_rst),
            .gpdReq    (gpdReq[p]),
            .edpdEn    (edpdEn[p]),
            .energy    (energyS2[p]),
            .clrFlag   (clrFlag[p]),
            .maskBit   (mask[p][PPDEW_ENERGY_BIT]),
            .pstate    (pstate[p]),
            .flag      (flag[p]),
            .event_out (portEvt[p]),
            .wake      (wake[p])
        );
    end

    // register writes and top status; phy event bits follow the source, the wake bit is cleared by software
    always_comb begin
        next_gpdReq = gpdReq;
        next_edpdEn = edpdEn;
        next_mask   = mask;
        next_topEn  = topEn;
        next_irqOe  = irqOe;
        next_topSts = topSts;
        if (wr) begin
            if (apbReq.paddr == PPDEW_PWR_CTRL_OFS) begin
                next_gpdReq = {apbReq.pwdata[8+PPDEW_GPD_BIT], apbReq.pwdata[PPDEW_GPD_BIT]};
                next_edpdEn = {apbReq.pwdata[8+PPDEW_EDPD_BIT], apbReq.pwdata[PPDEW_EDPD_BIT]};
            end else if (apbReq.paddr == PPDEW_MASK1_OFS) begin
                next_mask[0] = apbReq.pwdata[7:0];
            end else if (apbReq.paddr == PPDEW_MASK2_OFS) begin
                next_mask[1] = apbReq.pwdata[7:0];
            end else if (apbReq.paddr == PPDEW_TOP_EN_OFS) begin
                next_topEn = apbReq.pwdata[2:0];
            end else if (apbReq.paddr == PPDEW_IRQ_CFG_OFS) begin
                next_irqOe = apbReq.pwdata[0];
            end else if (apbReq.paddr == PPDEW_TOP_CLR_OFS) begin
                next_topSts[PPDEW_WAKE_BIT] = topSts[PPDEW_WAKE_BIT]
                                              & ~apbReq.pwdata[PPDEW_WAKE_BIT];
            end
        end
        next_topSts[PPDEW_P1_BIT] = portEvt[0];
        next_topSts[PPDEW_P2_BIT] = portEvt[1];
        if (|wake) next_topSts[PPDEW_WAKE_BIT] = 1'b1; // set wins over clear
    end

    // read mux; unmapped addresses answer with pslverr
    always_comb begin
        next_prdata = 32'h0;
        hit = 1'b1;
        if (apbReq.paddr == PPDEW_PWR_CTRL_OFS) begin
            next_prdata = {22'h0, edpdEn[1], gpdReq[1], 6'h0, edpdEn[0], gpdReq[0]};
        end else if (apbReq.paddr == PPDEW_PWR_STAT_OFS) begin
            next_prdata = {22'h0, pstate[1], 6'h0, pstate[0]};
        end else if (apbReq.paddr == PPDEW_SRC1_OFS) begin
            next_prdata = {24'h0, flag[0], 7'h0};
        end else if (apbReq.paddr == PPDEW_SRC2_OFS) begin
            next_prdata = {24'h0, flag[1], 7'h0};
        end else if (apbReq.paddr == PPDEW_MASK1_OFS) begin
            next_prdata = {24'h0, mask[0]};
        end else if (apbReq.paddr == PPDEW_MASK2_OFS) begin
            next_prdata = {24'h0, mask[1]};
        end else if (apbReq.paddr == PPDEW_TOP_STS_OFS) begin
            next_prdata = {29'h0, topSts};
        end else if (apbReq.paddr == PPDEW_TOP_EN_OFS) begin
            next_prdata = {29'h0, topEn};
        end else if (apbReq.paddr == PPDEW_IRQ_CFG_OFS) begin
            next_prdata = {31'h0, irqOe};
        end else if (apbReq.paddr != PPDEW_TOP_CLR_OFS) begin
            hit = 1'b0;
        end
        next_pslverr = apbReq.psel && !apbReq.penable && !hit;
    end

    // no wait state: answer prepared in setup, pready high in the first access cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gpdReq       <= 2'h0;
            edpdEn       <= 2'h0;
            mask[0]      <= PPDEW_MASK_RST;
            mask[1]      <= PPDEW_MASK_RST;
            topSts       <= 3'h0;
            topEn        <= 3'h0;
            irqOe        <= 1'b0;
            prdata       <= 32'h0;
            pready       <= 1'b0;
            pslverr      <= 1'b0;
            phyPowerDown <= 2'h0;
            phyMgmtAlive <= 2'h0;
            irq          <= 1'b0;
        end else begin
            gpdReq       <= next_gpdReq;
            edpdEn       <= next_edpdEn;
            mask         <= next_mask;
            topSts       <= next_topSts;
            topEn        <= next_topEn;
            irqOe        <= next_irqOe;
            prdata       <= rd ? next_prdata : 32'h0;
            pready       <= apbReq.psel && !apbReq.penable;
            pslverr      <= next_pslverr;
            phyPowerDown <= {pstate[1] != PPDEW_RUN, pstate[0] != PPDEW_RUN};
            phyMgmtAlive <= 2'h3;
            irq          <= irqOe && |(next_topSts & topEn);
        end
    end

    irq_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
        !irqOe |=> !irq)
        else $error("irq without output enable");
    top_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
        portEvt[0] |=> topSts[PPDEW_P1_BIT])
        else $error("port1 event not in top status");
    top_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        topSts[PPDEW_P2_BIT] && flag[1] && mask[1][PPDEW_ENERGY_BIT] && !clrFlag[1]
        |=> ##1 topSts[PPDEW_P2_BIT])
        else $error("top bit dropped before source cleared");
    gpd_out_a: assert property (@(posedge clk) disable iff (sys_rst)
        pstate[0] == PPDEW_GPD |=> phyPowerDown[0] && phyMgmtAlive[0])
        else $error("gpd output wrong");
endmodule

// ==== ppdew_irq_host.sv ====
// host side model: the service routine watching the irq line
// assumes irq is a registered level in the clk domain
`timescale 1ns/100ps
module ppdew_irq_host (
    input  wire logic   clk,
    input  wire logic   sys_rst,
    input  wire logic   irq,
    output logic [7:0]  irqCount
);
    logic irqLast;
    // a level counts once per assertion, so a slow service never double counts
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irqCount <= 8'h00;
            irqLast  <= 1'b0;
        end else begin
            irqLast <= irq;
            if (irq && !irqLast) begin
                irqCount <= irqCount + 8'h01;
            end
        end
    end
endmodule

// ==== ppdew_test.sv ====
// self-checking bench for the phy power-down and energy wake block
// assumes the apb slave answers with pready after one setup cycle
`timescale 1ns/100ps
module ppdew_test;
    import ppdew_pkg::*;
    typedef struct packed {
        logic [7:0]  wa;
        logic [31:0] wd;
        logic [7:0]  ra;
        logic [31:0] re;
        logic [1:0]  pd;
    } ppdew_row_t;
    logic           clk = 1'b0;
    logic           sys_rst;
    ppdew_apb_req_t apbReq;
    logic [31:0]    prdata;
    logic           pready;
    logic           pslverr;
    logic [1:0]     cableEnergy;
    logic [1:0]     phyPowerDown;
    logic [1:0]     phyMgmtAlive;
    logic           irq;
    logic [7:0]     irqCount;
    logic [31:0]    rd;
    logic           er;
    int             errCount = 0;
    int             samplesChecked = 0;
    int             cyc = 0;
    // write then read back; the write to status is read only and must not stick
    ppdew_row_t     rows [6] = '{
        '{PPDEW_PWR_CTRL_OFS, 32'h1, PPDEW_PWR_STAT_OFS, 32'h3, 2'b01},
        '{PPDEW_PWR_CTRL_OFS, 32'h100, PPDEW_PWR_STAT_OFS, 32'h300, 2'b10},
        '{PPDEW_PWR_CTRL_OFS, 32'h101, PPDEW_PWR_STAT_OFS, 32'h303, 2'b11},
        '{PPDEW_PWR_CTRL_OFS, 32'h0, PPDEW_PWR_STAT_OFS, 32'h0, 2'b00},
        '{PPDEW_TOP_STS_OFS, 32'hffffffff, PPDEW_TOP_STS_OFS, 32'h0, 2'b00},
        '{PPDEW_PWR_CTRL_OFS, 32'h202, PPDEW_PWR_STAT_OFS, 32'h101, 2'b11}};

    always #10 clk = ~clk;

    ppdew_top ppdew_top_i (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .apbReq       (apbReq),
        .prdata       (prdata),
        .pready       (pready),
        .pslverr      (pslverr),
        .cableEnergy  (cableEnergy),
        .phyPowerDown (phyPowerDown),
        .phyMgmtAlive (phyMgmtAlive),
        .irq          (irq)
    );
    ppdew_irq_host ppdew_irq_host_i (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .irq      (irq),
        .irqCount (irqCount)
    );

    task automatic conclude;
        if (errCount == 0 && samplesChecked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            errCount++;
        end
    endtask

    // one apb transfer; n idle edges after release keep strobes apart
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input int n = 1);
        apbReq <= '{1'b1, 1'b0, wr, a, wd};
        @(posedge clk);
        apbReq.penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        apbReq <= '0;
        repeat (n) @(posedge clk);
    endtask

    task automatic stat(input logic [1:0] top, input logic pin);
        apb(1'b0, PPDEW_TOP_STS_OFS, 32'h0);
        chk(32'(rd[1:0]), 32'(top));
        chk(32'(irq), 32'(pin));
    endtask

    // full energy wake and interrupt path for one port, gating opened one step at a time
    task automatic portEvent(input int p);
        logic [7:0] mo;
        logic [7:0] so;
        logic [1:0] b;
        mo = p ? PPDEW_MASK2_OFS : PPDEW_MASK1_OFS;
        so = p ? PPDEW_SRC2_OFS : PPDEW_SRC1_OFS;
        b = 2'(1 << p);
        cableEnergy[p] <= 1'b1;
        repeat (8) @(posedge clk);
        // energy held through the power-state checks; a dropped line lets the port fall back into edpd
        apb(1'b0, PPDEW_PWR_STAT_OFS, 32'h0);
        chk((rd >> (8 * p)) & 32'h3, 32'h0);
        chk(32'(phyPowerDown[p]), 32'h0);
        cableEnergy[p] <= 1'b0;
        apb(1'b0, so, 32'h0);
        chk(32'(rd[7]), 32'h1);
        stat(2'b00, 1'b0);
        chk(32'(rd[PPDEW_WAKE_BIT]), 32'h1);
        apb(1'b1, mo, 32'h80, 8);
        stat(b, 1'b0);
        apb(1'b1, PPDEW_TOP_EN_OFS, 32'(b), 8);
        stat(b, 1'b0);
        apb(1'b1, PPDEW_IRQ_CFG_OFS, 32'h1, 8);
        stat(b, 1'b1);
        chk(32'(irqCount), 32'(p + 1));
        apb(1'b1, PPDEW_TOP_CLR_OFS, 32'h7, 8);
        stat(b, 1'b1);
        chk(32'(rd[PPDEW_WAKE_BIT]), 32'h0);
        apb(1'b1, so, 32'h80, 8);
        stat(2'b00, 1'b0);
        apb(1'b1, PPDEW_IRQ_CFG_OFS, 32'h0);
        apb(1'b1, PPDEW_TOP_EN_OFS, 32'h0);
        apb(1'b1, mo, 32'h0);
    endtask

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            errCount++;
            conclude();
        end
    end

    initial begin
        apbReq = '0;
        cableEnergy = 2'b00;
        sys_rst = 1'b1;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, PPDEW_MASK1_OFS, 32'h0);
        chk(rd, 32'(PPDEW_MASK_RST));
        stat(2'b00, 1'b0);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].wa, rows[i].wd);
            apb(1'b0, rows[i].ra, 32'h0);
            chk(rd, rows[i].re);
            chk(32'(phyPowerDown), 32'(rows[i].pd));
            chk(32'(phyMgmtAlive), 32'h3);
        end
        for (int p = 0; p < 2; p++) begin
            portEvent(p);
        end
        // cable energy must not lift a general power-down
        apb(1'b1, PPDEW_PWR_CTRL_OFS, 32'h1, 8);
        cableEnergy[0] <= 1'b1;
        repeat (4) @(posedge clk);
        apb(1'b0, PPDEW_PWR_STAT_OFS, 32'h0);
        chk(rd & 32'h3, 32'h3);
        cableEnergy[0] <= 1'b0;
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        conclude();
    end
endmodule
